// [aaif_regs.svh]
// Register offsets, field positions, reset values and timing figures of the flag block
`ifndef AAIF_REGS_SVH
`define AAIF_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (page 0)
// ----------------------------------------------------------------------
`define AAIF_OFS_OVF_STICKY   7'h2a
`define AAIF_OFS_OVF_LIVE     7'h2b
`define AAIF_OFS_EVT_STICKY   7'h2d
`define AAIF_OFS_EVT_LIVE     7'h2f
`define AAIF_OFS_CTRL_A       7'h30
`define AAIF_OFS_CTRL_B       7'h31

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AAIF_BIT_OVF_LEFT     3
`define AAIF_BIT_OVF_RIGHT    2
`define AAIF_BIT_OVF_SHIFT    1
`define AAIF_BIT_EVT_NOISE_L  6
`define AAIF_BIT_EVT_NOISE_R  5
`define AAIF_BIT_EVT_ENG_STD  4
`define AAIF_BIT_EVT_ENG_AUX  3
`define AAIF_BIT_CTL_NOISE    4
`define AAIF_BIT_CTL_ENGINE   2
`define AAIF_BIT_CTL_DATA     1
`define AAIF_BIT_CTL_REPEAT   0
`define AAIF_CTL_WRITE_MASK   8'h17

// ----------------------------------------------------------------------
// Reset values and pin function codes
// ----------------------------------------------------------------------
`define AAIF_RST_FLAGS        8'h00
`define AAIF_RST_CTRL         8'h00
`define AAIF_MIC_FUNC_IRQ_A   4'h5
`define AAIF_MIC_FUNC_IRQ_B   4'h6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AAIF_CLK_MHZ          20
`define AAIF_PULSE_TIME_US    2000
`define AAIF_PERIOD_TIME_US   4000

`endif

// [aaif_pkg.sv]
// Types shared by the audio ADC interrupt flag block
package aaif_pkg;

  // Event sources arriving from the converter, shifter, gain loop and engine
  typedef struct packed {
    logic leftOvf;
    logic rightOvf;
    logic shiftOvf;
    logic leftNoise;
    logic rightNoise;
    logic engStd;
    logic engAux;
    logic dataAvail;
  } aaif_src_s;

  // Pulse generator states, one-hot
  typedef enum logic [2:0] {
    PG_IDLE = 3'b001,
    PG_HIGH = 3'b010,
    PG_LOW  = 3'b100
  } aaif_pulse_e;

endpackage

// [aaif_flags.sv]
// Interrupt flags, live flags and two pulse-generating interrupt outputs
`timescale 1ns/1ps
`include "aaif_regs.svh"

module aaif_flags
  import aaif_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES  = `AAIF_PULSE_TIME_US * `AAIF_CLK_MHZ,
  parameter int unsigned PERIOD_CYCLES = `AAIF_PERIOD_TIME_US * `AAIF_CLK_MHZ
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire aaif_src_s  src,
  input  wire logic [6:0] regAddr,
  input  wire logic       regRdEn,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  input  wire logic [3:0] micClkFunc,
  output logic            irqOutA,
  output logic            irqOutB,
  output logic            micClockPin,
  output logic            micClockPinOe
);

  localparam int CNT_W = $clog2(PERIOD_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The low phase needs at least one cycle, so the period must exceed the pulse
  if (PULSE_CYCLES < 1 || PERIOD_CYCLES <= PULSE_CYCLES) begin : g_bad_timing
    $error("aaif_flags: pulse must be at least one cycle and shorter than period");
  end

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  function automatic logic regHit(input logic [6:0] addr, input logic [6:0] ofs);
    regHit = (addr == ofs);
  endfunction

  wire logic rdOvfSticky = regRdEn && regHit(regAddr, `AAIF_OFS_OVF_STICKY);
  wire logic rdEvtSticky = regRdEn && regHit(regAddr, `AAIF_OFS_EVT_STICKY);
  wire logic wrCtrlA     = regWrEn && regHit(regAddr, `AAIF_OFS_CTRL_A);
  wire logic wrCtrlB     = regWrEn && regHit(regAddr, `AAIF_OFS_CTRL_B);
  // Either sticky read also ends a repeating pulse train
  wire logic flagRead    = rdOvfSticky || rdEvtSticky;

  // ----------------------------------------------------------------------
  // Source edge detection
  // ----------------------------------------------------------------------
  aaif_src_s srcQ;

  // Previous source levels; a held level gives no new edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      srcQ <= '0;
    end else begin
      srcQ <= src;
    end
  end

  wire aaif_src_s srcRise = src & ~srcQ;

  // ----------------------------------------------------------------------
  // Sticky flag registers
  // ----------------------------------------------------------------------
  logic [7:0] ovfSticky;
  logic [7:0] evtSticky;
  logic [7:0] ovfSet;
  logic [7:0] evtSet;
  logic [7:0] next_ovfSticky;
  logic [7:0] next_evtSticky;

  // New edges only; reserved bit positions stay zero
  always_comb begin
    ovfSet = 8'h00;
    ovfSet[`AAIF_BIT_OVF_LEFT]  = srcRise.leftOvf;
    ovfSet[`AAIF_BIT_OVF_RIGHT] = srcRise.rightOvf;
    ovfSet[`AAIF_BIT_OVF_SHIFT] = srcRise.shiftOvf;
    evtSet = 8'h00;
    evtSet[`AAIF_BIT_EVT_NOISE_L] = srcRise.leftNoise;
    evtSet[`AAIF_BIT_EVT_NOISE_R] = srcRise.rightNoise;
    evtSet[`AAIF_BIT_EVT_ENG_STD] = srcRise.engStd;
    evtSet[`AAIF_BIT_EVT_ENG_AUX] = srcRise.engAux;
  end

  // Set beats clear so an edge during the read survives to the next one
  assign next_ovfSticky = (rdOvfSticky ? 8'h00 : ovfSticky) | ovfSet;
  assign next_evtSticky = (rdEvtSticky ? 8'h00 : evtSticky) | evtSet;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovfSticky <= `AAIF_RST_FLAGS;
      evtSticky <= `AAIF_RST_FLAGS;
    end else begin
      ovfSticky <= next_ovfSticky;
      evtSticky <= next_evtSticky;
    end
  end

  // ----------------------------------------------------------------------
  // Live flag views
  // ----------------------------------------------------------------------
  logic [7:0] ovfLive;
  logic [7:0] evtLive;

  // Taken straight from the sources at the read, no latching
  always_comb begin
    ovfLive = 8'h00;
    ovfLive[`AAIF_BIT_OVF_LEFT]  = src.leftOvf;
    ovfLive[`AAIF_BIT_OVF_RIGHT] = src.rightOvf;
    ovfLive[`AAIF_BIT_OVF_SHIFT] = src.shiftOvf;
    evtLive = 8'h00;
    evtLive[`AAIF_BIT_EVT_NOISE_L] = src.leftNoise;
    evtLive[`AAIF_BIT_EVT_NOISE_R] = src.rightNoise;
    evtLive[`AAIF_BIT_EVT_ENG_STD] = src.engStd;
    evtLive[`AAIF_BIT_EVT_ENG_AUX] = src.engAux;
  end

  // ----------------------------------------------------------------------
  // Interrupt output control registers
  // ----------------------------------------------------------------------
  logic [7:0] ctrlA;
  logic [7:0] ctrlB;

  // Only bits 4,2,1,0 hold state; reserved bits cannot be set by a stray write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlA <= `AAIF_RST_CTRL;
      ctrlB <= `AAIF_RST_CTRL;
    end else begin
      if (wrCtrlA) begin
        ctrlA <= regWrData & `AAIF_CTL_WRITE_MASK;
      end
      if (wrCtrlB) begin
        ctrlB <= regWrData & `AAIF_CTL_WRITE_MASK;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  logic [7:0] rdMux;

  // Unmapped and reserved indices read zero; data appears one edge later
  always_comb begin
    case (regAddr)
      `AAIF_OFS_OVF_STICKY: rdMux = ovfSticky;
      `AAIF_OFS_OVF_LIVE:   rdMux = ovfLive;
      `AAIF_OFS_EVT_STICKY: rdMux = evtSticky;
      `AAIF_OFS_EVT_LIVE:   rdMux = evtLive;
      `AAIF_OFS_CTRL_A:     rdMux = ctrlA;
      `AAIF_OFS_CTRL_B:     rdMux = ctrlB;
      default:              rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt source gating and pulse generators
  // ----------------------------------------------------------------------
  wire logic noiseLvl  = src.leftNoise | src.rightNoise;
  wire logic engineLvl = src.engStd | src.engAux | src.leftOvf | src.rightOvf | src.shiftOvf;
  wire logic [7:0] ctrlArr [2] = '{ctrlA, ctrlB};

  logic [1:0]       irqOut;
  logic [1:0]       trigger;
  aaif_pulse_e      pgState [2];
  logic [CNT_W-1:0] pgCnt   [2];

  for (genvar g = 0; g < 2; g++) begin : g_out
    logic             reqLvl;
    logic             reqLvlQ;
    logic             repeatArmed;
    aaif_pulse_e      next_state;
    logic [CNT_W-1:0] next_cnt;

    // Enabled sources ORed; each control register steers only its own output
    assign reqLvl = (ctrlArr[g][`AAIF_BIT_CTL_NOISE]  & noiseLvl)
                  | (ctrlArr[g][`AAIF_BIT_CTL_ENGINE] & engineLvl)
                  | (ctrlArr[g][`AAIF_BIT_CTL_DATA]   & src.dataAvail);
    assign trigger[g] = reqLvl & ~reqLvlQ;

    // Next state; a trigger while busy in one-pulse mode is absorbed
    always_comb begin
      next_state = pgState[g];
      next_cnt   = pgCnt[g];
      case (pgState[g])
        PG_IDLE: begin
          if (trigger[g]) begin
            next_state = PG_HIGH;
            next_cnt   = CNT_W'(PULSE_CYCLES - 1);
          end
        end
        PG_HIGH: begin
          if (pgCnt[g] != '0) begin
            next_cnt = pgCnt[g] - 1'b1;
          end else if (repeatArmed && !flagRead) begin
            next_state = PG_LOW;
            next_cnt   = CNT_W'(PERIOD_CYCLES - PULSE_CYCLES - 1);
          end else begin
            next_state = PG_IDLE;
          end
        end
        PG_LOW: begin
          if (!repeatArmed || flagRead) begin
            next_state = PG_IDLE;
          end else if (pgCnt[g] != '0) begin
            next_cnt = pgCnt[g] - 1'b1;
          end else begin
            next_state = PG_HIGH;
            next_cnt   = CNT_W'(PULSE_CYCLES - 1);
          end
        end
        default: begin
          next_state = PG_IDLE;
          next_cnt   = '0;
        end
      endcase
    end

    // Repeat stays armed until a sticky read or a clear repeat bit; a fresh trigger re-arms it
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        reqLvlQ     <= 1'b0;
        repeatArmed <= 1'b0;
        pgState[g]  <= PG_IDLE;
        pgCnt[g]    <= '0;
      end else begin
        reqLvlQ     <= reqLvl;
        repeatArmed <= (trigger[g] && ctrlArr[g][`AAIF_BIT_CTL_REPEAT])
                     || (repeatArmed && !flagRead
                         && ctrlArr[g][`AAIF_BIT_CTL_REPEAT]);
        pgState[g]  <= next_state;
        pgCnt[g]    <= next_cnt;
      end
    end

    // Output flop keeps the pin glitch-free
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        irqOut[g] <= 1'b0;
      end else begin
        irqOut[g] <= (next_state == PG_HIGH);
      end
    end
  end

  assign irqOutA = irqOut[0];
  assign irqOutB = irqOut[1];

  // ----------------------------------------------------------------------
  // Mic clock pin function select
  // ----------------------------------------------------------------------
  // Other function codes belong to pin logic outside; pin is released there
  wire logic selA = (micClkFunc == `AAIF_MIC_FUNC_IRQ_A);
  wire logic selB = (micClkFunc == `AAIF_MIC_FUNC_IRQ_B);
  assign micClockPin   = (selA & irqOutA) | (selB & irqOutB);
  assign micClockPinOe = selA | selB;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] highRun;

  // Length of the current high stretch on the first output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      highRun <= '0;
    end else if (irqOutA) begin
      highRun <= highRun + 1'b1;
    end else begin
      highRun <= '0;
    end
  end

  a_ovf_edge_sets: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(src.leftOvf) |=> ovfSticky[`AAIF_BIT_OVF_LEFT] && !ovfSticky[0]
  ) else $error("left overflow edge did not set sticky flag");

  a_read_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    (rdOvfSticky && ovfSet == 8'h00) |=> ovfSticky == 8'h00
  ) else $error("sticky overflow read did not clear flags");

  a_persist_no_set: assert property (
    @(posedge core_clk) disable iff (rst)
    (rdEvtSticky && srcQ.leftNoise && src.leftNoise) ##1 src.leftNoise
      |=> !evtSticky[`AAIF_BIT_EVT_NOISE_L]
  ) else $error("held noise level set sticky flag again");

  a_event_survives: assert property (
    @(posedge core_clk) disable iff (rst)
    (rdOvfSticky && srcRise.leftOvf) |=> ovfSticky[`AAIF_BIT_OVF_LEFT]
  ) else $error("event during read was lost");

  a_live_at_read: assert property (
    @(posedge core_clk) disable iff (rst)
    (regRdEn && regAddr == `AAIF_OFS_EVT_LIVE)
      |=> regRdData == {1'b0, $past(src.leftNoise), $past(src.rightNoise),
                        $past(src.engStd), $past(src.engAux), 3'b000}
  ) else $error("live event read wrong");

  a_ctrl_masked: assert property (
    @(posedge core_clk) disable iff (rst)
    wrCtrlB |=> ctrlB == ($past(regWrData) & 8'h17) && $stable(ctrlA)
  ) else $error("control write not masked or disturbed other output");

  a_pulse_starts: assert property (
    @(posedge core_clk) disable iff (rst)
    (trigger[0] && pgState[0] == PG_IDLE) |=> irqOutA [*8]
  ) else $error("first output pulse did not start");

  a_pulse_width: assert property (
    @(posedge core_clk) disable iff (rst)
    $fell(irqOutA) && !ctrlA[0] |-> highRun == CNT_W'(PULSE_CYCLES)
  ) else $error("single pulse width wrong");

  a_gate_off: assert property (
    @(posedge core_clk) disable iff (rst)
    (ctrlA[4:1] == 4'h1 && !src.dataAvail) |-> !trigger[0]
  ) else $error("trigger without enabled source");

  a_repeat_stop: assert property (
    @(posedge core_clk) disable iff (rst)
    (flagRead && !trigger[1] && pgState[1] == PG_LOW) |=> pgState[1] == PG_IDLE
  ) else $error("repeating pulses not stopped by flag read");

  a_mic_pin: assert property (
    @(posedge core_clk) disable iff (rst)
    selB |-> micClockPinOe && micClockPin == irqOutB
  ) else $error("mic clock pin not carrying second output");

endmodule

// [aaif_host_model.sv]
// Host-side model that watches both interrupt pins and measures their pulses
`timescale 1ns/1ps

module aaif_host_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       irqOutA,
  input  wire logic       irqOutB,
  output logic      [7:0] countA,
  output logic      [7:0] countB,
  output logic      [7:0] widthA,
  output logic      [7:0] widthB
);
  // ----------------------------------------------------------------------
  // Pulse measurement
  // ----------------------------------------------------------------------
  logic [7:0] runA;
  logic [7:0] runB;
  logic       prevA;
  logic       prevB;

  // Rising edges are counted; width is latched when the pin drops, so a
  // train shows the width of its latest finished pulse only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {countA, countB, widthA, widthB, runA, runB} <= '0;
      {prevA, prevB} <= 2'b00;
    end else begin
      prevA <= irqOutA;
      prevB <= irqOutB;
      runA  <= irqOutA ? runA + 8'h01 : 8'h00;
      runB  <= irqOutB ? runB + 8'h01 : 8'h00;
      if (irqOutA && !prevA) countA <= countA + 8'h01;
      if (irqOutB && !prevB) countB <= countB + 8'h01;
      if (!irqOutA && prevA) widthA <= runA;
      if (!irqOutB && prevB) widthB <= runB;
    end
  end
endmodule

// [test_aaif_flags.sv]
// Self-checking testbench of the audio ADC interrupt flag block
`timescale 1ns/1ps
`include "aaif_regs.svh"

module test_aaif_flags
  import aaif_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and settings
  // ----------------------------------------------------------------------
  // Short counts keep the run brief; the design's own check needs eight
  localparam int PULSE  = 8;
  localparam int PERIOD = 20;
  localparam logic [7:0] CTL [4] = '{8'h10, 8'h04, 8'h04, 8'h02};
  localparam logic [6:0] OFS [6] = '{7'h2a, 7'h2b, 7'h2d, 7'h2f, 7'h30, 7'h31};

  logic       core_clk;
  logic       rst;
  aaif_src_s  src;
  logic [6:0] regAddr;
  logic       regRdEn;
  logic       regWrEn;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic [3:0] micClkFunc;
  logic       irqOutA;
  logic       irqOutB;
  logic       micClockPin;
  logic       micClockPinOe;
  logic [7:0] countA;
  logic [7:0] countB;
  logic [7:0] widthA;
  logic [7:0] widthB;
  logic [7:0] c0;
  int         failures;
  int         cmpCount;

  aaif_flags #(.PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD)) aaif_flags_i (
    .core_clk(core_clk), .rst(rst), .src(src), .regAddr(regAddr), .regRdEn(regRdEn),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
    .micClkFunc(micClkFunc), .irqOutA(irqOutA), .irqOutB(irqOutB),
    .micClockPin(micClockPin), .micClockPinOe(micClockPinOe));

  aaif_host_model aaif_host_model_i (
    .core_clk(core_clk), .rst(rst), .irqOutA(irqOutA), .irqOutB(irqOutB),
    .countA(countA), .countB(countB), .widthA(widthA), .widthB(widthB));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Verdict and end of run, shared with the watchdog
  task automatic close_out();
    if (failures == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobes start one negedge in, so back-to-back calls never touch a strobe twice
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge core_clk);
    regWrEn   = 1'b0;
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    chk(regRdData, exp);
  endtask

  task automatic setSrc(input int i, input logic v);
    case (i)
      0:       src.leftNoise = v;
      1:       src.leftOvf = v;
      2:       src.engStd = v;
      default: src.dataAvail = v;
    endcase
  endtask

  // Raise one source and expect n pulses on output o, none on the other
  task automatic pulseTry(input int o, input int i, input logic [7:0] n);
    logic [7:0] a0;
    logic [7:0] b0;
    a0 = countA;
    b0 = countB;
    setSrc(i, 1'b1);
    repeat (PULSE + 4) @(negedge core_clk);
    chk(o ? countB - b0 : countA - a0, n);
    chk(o ? countA - a0 : countB - b0, 8'h00);
    if (n != 8'h00) chk(o ? widthB : widthA, 8'(PULSE));
    setSrc(i, 1'b0);
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Whole sequence needs under a thousand cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    failures++;
    close_out();
  end

  initial begin
    {rst, regRdEn, regWrEn} = 3'b100;
    src = '0;
    regAddr = 7'h00;
    regWrData = 8'h00;
    micClkFunc = 4'h0;
    failures = 0;
    cmpCount = 0;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    foreach (OFS[i]) rdchk(OFS[i], 8'h00);
    rdchk(7'h2c, 8'h00);
    // Reserved control bits are only ever written with their reset value
    wr(`AAIF_OFS_CTRL_A, 8'h17);
    rdchk(`AAIF_OFS_CTRL_A, 8'h17);
    wr(`AAIF_OFS_CTRL_B, 8'h17);
    rdchk(`AAIF_OFS_CTRL_B, 8'h17);
    wr(`AAIF_OFS_CTRL_A, 8'h00);
    wr(`AAIF_OFS_CTRL_B, 8'h00);
    // Sticky versus live overflow flags
    src.leftOvf = 1'b1;
    rdchk(`AAIF_OFS_OVF_LIVE, 8'h08);
    rdchk(`AAIF_OFS_OVF_STICKY, 8'h08);
    rdchk(`AAIF_OFS_OVF_STICKY, 8'h00);
    {src.leftOvf, src.rightOvf, src.shiftOvf} = 3'b011;
    rdchk(`AAIF_OFS_OVF_STICKY, 8'h06);
    rdchk(`AAIF_OFS_OVF_LIVE, 8'h06);
    {src.rightOvf, src.shiftOvf} = 2'b00;
    // Event flags
    {src.leftNoise, src.rightNoise, src.engStd, src.engAux} = 4'hf;
    rdchk(`AAIF_OFS_EVT_LIVE, 8'h78);
    rdchk(`AAIF_OFS_EVT_STICKY, 8'h78);
    rdchk(`AAIF_OFS_EVT_STICKY, 8'h00);
    {src.leftNoise, src.rightNoise, src.engStd, src.engAux} = 4'h0;
    rdchk(`AAIF_OFS_EVT_LIVE, 8'h00);
    rdchk(`AAIF_OFS_EVT_STICKY, 8'h00);
    // New edge in the very cycle of a read survives it
    @(negedge core_clk);
    regAddr = `AAIF_OFS_OVF_STICKY;
    regRdEn = 1'b1;
    src.leftOvf = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    rdchk(`AAIF_OFS_OVF_STICKY, 8'h08);
    rdchk(`AAIF_OFS_OVF_STICKY, 8'h00);
    src.leftOvf = 1'b0;
    // Source enables, single pulse, both outputs
    for (int o = 0; o < 2; o++) begin
      for (int i = 0; i < 4; i++) begin
        wr(7'(`AAIF_OFS_CTRL_A + o), CTL[i]);
        pulseTry(o, i, 8'h01);
        wr(7'(`AAIF_OFS_CTRL_A + o), 8'h00);
        pulseTry(o, i, 8'h00);
      end
    end
    rdchk(`AAIF_OFS_OVF_STICKY, 8'h08);
    rdchk(`AAIF_OFS_EVT_STICKY, 8'h50);
    // Pulse trains stopped by a flag read, seen on the mic clock pin too
    for (int o = 0; o < 2; o++) begin
      micClkFunc = o ? `AAIF_MIC_FUNC_IRQ_B : `AAIF_MIC_FUNC_IRQ_A;
      wr(7'(`AAIF_OFS_CTRL_A + o), 8'h03);
      c0 = o ? countB : countA;
      src.dataAvail = 1'b1;
      repeat (2) @(negedge core_clk);
      chk({7'h00, micClockPin}, 8'h01);
      chk({7'h00, micClockPinOe}, 8'h01);
      // Output A is read in the first cycle of its low phase, output B in the fifth
      repeat (46 + 4 * o) @(negedge core_clk);
      chk((o ? countB : countA) - c0, 8'h03);
      rdchk(o ? `AAIF_OFS_EVT_STICKY : `AAIF_OFS_OVF_STICKY, 8'h00);
      repeat (50) @(negedge core_clk);
      chk((o ? countB : countA) - c0, 8'h03);
      src.dataAvail = 1'b0;
      wr(7'(`AAIF_OFS_CTRL_A + o), 8'h00);
    end
    micClkFunc = 4'h3;
    @(negedge core_clk);
    chk({7'h00, micClockPinOe}, 8'h00);
    close_out();
  end
endmodule
